// *** pkg/ohcd_regs.svh ***
// Purpose: constants of the OLED host command decoder
// Assumes: included by its bare name
// Notes:   command codes, reset values and field positions
`ifndef OHCD_REGS_SVH
`define OHCD_REGS_SVH
`define OHCD_CMD_COL_LO      4'h0
`define OHCD_CMD_COL_HI      4'h1
`define OHCD_CMD_SEG_DIS     4'h3
`define OHCD_CMD_ADDR_MODE   7'h10
`define OHCD_CMD_CONTRAST    8'h81
`define OHCD_CMD_REMAP       7'h50
`define OHCD_CMD_ENTIRE      7'h52
`define OHCD_CMD_REVERSE     7'h53
`define OHCD_CMD_PUMP        8'hAD
`define OHCD_CMD_DISP        7'h57
`define OHCD_CMD_PAGE        8'hB0
`define OHCD_CMD_SCAN        4'hC
`define OHCD_CMD_RES         8'hA9
`define OHCD_CMD_CLOCK       8'hD5
`define OHCD_CMD_PHASE       8'hD9
`define OHCD_CMD_COM_LVL     8'hDB
`define OHCD_CMD_SEGM_LVL    8'hDC
`define OHCD_CMD_RMW         8'hE0
`define OHCD_CMD_END         8'hEE
`define OHCD_RST_COL         8'h00
`define OHCD_RST_CONTRAST    8'h80
`define OHCD_RST_PUMP        8'h81
`define OHCD_RST_PAGE        5'h00
`define OHCD_RST_RES         2'h3
`define OHCD_RST_CLOCK       8'h50
`define OHCD_RST_PHASE       8'h22
`define OHCD_RST_LVL         8'h35
`define OHCD_RST_SEG_DIS     4'h0
`define OHCD_BUSY_BIT        7
`define OHCD_OFF_BIT         6
`define OHCD_BUSY_CYC        4'h2
`endif

// *** pkg/ohcd_pkg.sv ***
// Purpose: types of the OLED host command decoder
// Assumes: nothing
// Notes:   states for the second byte of double-byte commands
package ohcd_pkg;
  typedef enum logic [3:0] {
    OHCD_ARG_NONE, OHCD_ARG_CONTRAST, OHCD_ARG_PUMP, OHCD_ARG_PAGE,
    OHCD_ARG_RES, OHCD_ARG_CLOCK, OHCD_ARG_PHASE, OHCD_ARG_COM, OHCD_ARG_SEGM
  } ohcd_arg_t;
endpackage : ohcd_pkg

// *** design/ohcd_top.sv ***
// Purpose: host command interpreter of a dot-matrix OLED controller
// Assumes: one host access per strobe, synchronous to CLK_SYS_I
// Notes:   display RAM is 20 pages by 160 columns of flip-flops
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "ohcd_regs.svh"

// Behaviour
// - end command leaves modify mode and restores the saved column, or the saved page in vertical mode
// - in modify mode reads keep the address, only writes advance it
// - data write stores a byte at the current address then advances column or page
// - status read gives busy on top bit; commands are ignored while busy
// - status bit six is high while the display is off
// - low six status bits are a fixed identity code
// - data read returns the RAM byte then advances column or page
// - first data read after a column set returns a dummy value
// - no data read path in serial mode
// - two commands load column low and high nibbles
// - addressing mode bit selects vertical or page; reset is page
// - contrast takes a second byte; reset value 80H
// - remap bit selects normal or reversed segment order
// - entire display bit forces all pixels on
// - reverse bit inverts pixel polarity
// - pump command takes setting field and enable; reset 81H
// - display on/off bit; reset is off
// - page command second byte loads page address; reset 00H
// - scan command bit three selects reverse common scan
// - resolution command second byte low two bits; reset 03H
// - clock command second byte holds trim and divide ratio; reset 50H
// - phase command second byte holds discharge and precharge; reset 22H
// - common and segment level commands store a byte; reset 35H
// - 3xH command loads the segment discharge level nibble
module ohcd_top
  import ohcd_pkg::*;
#(
  parameter logic [5:0] CHIP_IDENT = 6'h2A  // arbitrary value
) (
  // clock, reset, enable
  input  wire logic       CLK_SYS_I,
  input  wire logic       RST_N_I,
  input  wire logic       CE_I,
  // host port
  input  wire logic       CMD_DATA_SELECT_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  input  wire logic       SERIAL_MODE_I,
  output logic      [7:0] RDATA_O,
  // display settings, running address and busy
  output logic      [7:0] CONTRAST_O,
  output logic            SEG_REMAP_O,
  output logic            ENTIRE_ON_O,
  output logic            REVERSE_O,
  output logic      [2:0] PUMP_SETTING_FIELD_O,
  output logic            PUMP_EN_O,
  output logic            DISPLAY_ON_O,
  output logic            SCAN_REV_O,
  output logic      [1:0] RESOLUTION_O,
  output logic      [7:0] CLOCK_CFG_O,
  output logic      [7:0] PHASE_O,
  output logic      [7:0] COMMON_DESELECT_LEVEL_O,
  output logic      [7:0] SEGMENT_PRECHARGE_LEVEL_O,
  output logic      [3:0] SEGMENT_DISCHARGE_LEVEL_O,
  output logic            VERTICAL_O,
  output logic      [7:0] COLUMN_O,
  output logic      [4:0] PAGE_O,
  output logic            BUSY_O
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  logic [7:0] ram_q [0:19][0:159];
  ohcd_arg_t  arg_q;
  logic [7:0] col_q, col_save_q;
  logic [4:0] page_q, page_save_q;
  logic       rmw_q, dummy_q;
  logic [3:0] busy_q;

  // ---------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------
  // busy rejects commands
  wire busy     = (busy_q != 4'h0);
  wire go       = CE_I && !busy;
  wire cmd_wr   = go && WR_I && !CMD_DATA_SELECT_I;
  wire dat_wr   = go && WR_I && CMD_DATA_SELECT_I;
  // serial mode has no data read path; status reads still work
  wire dat_rd   = go && RD_I && CMD_DATA_SELECT_I && !SERIAL_MODE_I;
  wire stat_rd  = CE_I && RD_I && !CMD_DATA_SELECT_I;
  wire in_arg   = (arg_q != OHCD_ARG_NONE);
  wire single   = cmd_wr && !in_arg;
  wire [7:0] c  = WDATA_I;
  // the array spans only the real panel; other addresses drop writes and read 00
  wire col_ok   = (col_q < 8'hA0);
  wire ram_hit  = col_ok && (page_q < 5'h14);
  // single-byte and argument decodes shared by the address logic and the checks
  wire op_col_lo = single && (c[7:4] == `OHCD_CMD_COL_LO);
  wire op_col_hi = single && (c[7:4] == `OHCD_CMD_COL_HI);
  wire op_rmw    = single && (c == `OHCD_CMD_RMW);
  wire op_end    = single && (c == `OHCD_CMD_END) && rmw_q;
  wire op_page   = cmd_wr && (arg_q == OHCD_ARG_PAGE);

  // next running address after one data access
  function automatic logic [12:0] adv(input logic v, input logic [7:0] col,
                                      input logic [4:0] pg);
    adv = v ? {col, pg + 5'h1} : {col + 8'h1, pg};
  endfunction

  // opcode to argument state
  wire ohcd_arg_t arg_next =
      (c == `OHCD_CMD_CONTRAST) ? OHCD_ARG_CONTRAST :
      (c == `OHCD_CMD_PUMP)     ? OHCD_ARG_PUMP :
      (c == `OHCD_CMD_PAGE)     ? OHCD_ARG_PAGE :
      (c == `OHCD_CMD_RES)      ? OHCD_ARG_RES :
      (c == `OHCD_CMD_CLOCK)    ? OHCD_ARG_CLOCK :
      (c == `OHCD_CMD_PHASE)    ? OHCD_ARG_PHASE :
      (c == `OHCD_CMD_COM_LVL)  ? OHCD_ARG_COM :
      (c == `OHCD_CMD_SEGM_LVL) ? OHCD_ARG_SEGM : OHCD_ARG_NONE;

  wire [12:0] nxt = adv(VERTICAL_O, col_q, page_q);

  // ---------------------------------------------------------------------
  // command and argument registers
  // ---------------------------------------------------------------------
  // undefined codes fall through unchanged
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      arg_q                     <= OHCD_ARG_NONE;
      CONTRAST_O                <= `OHCD_RST_CONTRAST;
      SEG_REMAP_O               <= 1'b0;
      ENTIRE_ON_O               <= 1'b0;
      REVERSE_O                 <= 1'b0;
      {PUMP_SETTING_FIELD_O, PUMP_EN_O} <= 4'(`OHCD_RST_PUMP); // only the low nibble is kept
      DISPLAY_ON_O              <= 1'b0;
      SCAN_REV_O                <= 1'b0;
      RESOLUTION_O              <= `OHCD_RST_RES;
      CLOCK_CFG_O               <= `OHCD_RST_CLOCK;
      PHASE_O                   <= `OHCD_RST_PHASE;
      COMMON_DESELECT_LEVEL_O   <= `OHCD_RST_LVL;
      SEGMENT_PRECHARGE_LEVEL_O <= `OHCD_RST_LVL;
      SEGMENT_DISCHARGE_LEVEL_O <= `OHCD_RST_SEG_DIS;
      VERTICAL_O                <= 1'b0;
    end else if (cmd_wr && in_arg) begin
      arg_q <= OHCD_ARG_NONE;
      unique case (arg_q)
        OHCD_ARG_CONTRAST: CONTRAST_O <= c;      // contrast byte
        OHCD_ARG_PUMP: {PUMP_SETTING_FIELD_O, PUMP_EN_O} <= c[3:0]; // pump
        OHCD_ARG_PAGE: ;                         // page loaded below
        OHCD_ARG_RES: RESOLUTION_O <= c[1:0];    // resolution
        OHCD_ARG_CLOCK: CLOCK_CFG_O <= c;        // clock byte
        OHCD_ARG_PHASE: PHASE_O <= c;            // phase byte
        OHCD_ARG_COM: COMMON_DESELECT_LEVEL_O <= c;   // levels
        OHCD_ARG_SEGM: SEGMENT_PRECHARGE_LEVEL_O <= c;
        default: ;
      endcase
    end else if (single) begin
      arg_q <= arg_next;
      if (c[7:1] == `OHCD_CMD_ADDR_MODE) VERTICAL_O <= c[0];
      if (c[7:1] == `OHCD_CMD_REMAP) SEG_REMAP_O <= c[0];
      if (c[7:1] == `OHCD_CMD_ENTIRE) ENTIRE_ON_O <= c[0];
      if (c[7:1] == `OHCD_CMD_REVERSE) REVERSE_O <= c[0];
      if (c[7:1] == `OHCD_CMD_DISP) DISPLAY_ON_O <= c[0];
      // scan direction; the low three bits are don't-care
      if (c[7:4] == `OHCD_CMD_SCAN) SCAN_REV_O <= c[3];
      if (c[7:4] == `OHCD_CMD_SEG_DIS) SEGMENT_DISCHARGE_LEVEL_O <= c[3:0];
    end
  end

  // ---------------------------------------------------------------------
  // running address, modify mode, dummy read
  // ---------------------------------------------------------------------
  // the saved copy lets the host redraw a cursor area repeatedly
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      col_q       <= `OHCD_RST_COL;
      page_q      <= `OHCD_RST_PAGE;
      col_save_q  <= `OHCD_RST_COL;
      page_save_q <= `OHCD_RST_PAGE;
      rmw_q       <= 1'b0;
      dummy_q     <= 1'b1;
    end else if (op_col_lo) begin
      col_q   <= {col_q[7:4], c[3:0]};
      dummy_q <= 1'b1;                   // dummy after column set
    end else if (op_col_hi) begin
      col_q   <= {c[3:0], col_q[3:0]};
      dummy_q <= 1'b1;
    end else if (op_page) begin
      page_q <= c[4:0];                  // page load
    end else if (op_rmw) begin
      rmw_q       <= 1'b1;
      col_save_q  <= col_q;
      page_save_q <= page_q;
    end else if (op_end) begin
      rmw_q <= 1'b0;
      if (VERTICAL_O) page_q <= page_save_q;
      else col_q <= col_save_q;
    end else if (dat_wr) begin
      {col_q, page_q} <= nxt;            // write advances
    end else if (dat_rd) begin
      if (dummy_q) dummy_q <= 1'b0;
      // modify mode holds address on read
      else if (!rmw_q) {col_q, page_q} <= nxt; // read advances
    end
  end

  // ---------------------------------------------------------------------
  // display RAM
  // ---------------------------------------------------------------------
  // store write byte
  always_ff @(posedge CLK_SYS_I) begin
    if (dat_wr && ram_hit) ram_q[page_q][col_q] <= c;
  end

  // ---------------------------------------------------------------------
  // read data and busy
  // ---------------------------------------------------------------------
  // off flag, identity
  wire [7:0] status = {busy, !DISPLAY_ON_O, CHIP_IDENT};
  wire [7:0] ram_rd = (dummy_q || !ram_hit) ? 8'h00 : ram_q[page_q][col_q];

  // busy counts down only while enabled, so a frozen block stays busy
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 8'h00;
      busy_q  <= `OHCD_BUSY_CYC;        // busy briefly after reset
      BUSY_O  <= 1'b1;
    end else if (CE_I) begin
      RDATA_O <= stat_rd ? status : (dat_rd ? ram_rd : 8'h00);
      if (busy) busy_q <= busy_q - 4'h1;
      BUSY_O  <= (busy_q > 4'h1);
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  property p_status_off;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      stat_rd |=> RDATA_O[`OHCD_OFF_BIT] == !$past(DISPLAY_ON_O);
  endproperty
  a_status_off: assert property (p_status_off) else $error("off flag wrong");

  property p_ident;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      stat_rd |=> RDATA_O[5:0] == CHIP_IDENT;
  endproperty
  a_ident: assert property (p_ident) else $error("ident wrong");

  property p_write_adv;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      dat_wr && !VERTICAL_O |=> COLUMN_O == $past(COLUMN_O) + 8'h1;
  endproperty
  a_write_adv: assert property (p_write_adv) else $error("column not advanced");

  property p_rmw_hold;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      dat_rd && rmw_q |=> $stable(col_q) && $stable(page_q);
  endproperty
  a_rmw_hold: assert property (p_rmw_hold) else $error("read moved address");

  property p_serial_rd;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      SERIAL_MODE_I && RD_I && CMD_DATA_SELECT_I && CE_I |=> RDATA_O == 8'h00;
  endproperty
  a_serial_rd: assert property (p_serial_rd) else $error("serial read data");

  property p_busy_ignore;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      busy |=> $stable(CONTRAST_O) && $stable(DISPLAY_ON_O);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("busy command taken");

  property p_end_restore;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      single && c == `OHCD_CMD_END && rmw_q && !VERTICAL_O |=> col_q == $past(col_save_q);
  endproperty
  a_end_restore: assert property (p_end_restore) else $error("column not restored");

  property p_contrast;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      cmd_wr && arg_q == OHCD_ARG_CONTRAST |=> CONTRAST_O == $past(WDATA_I);
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast not loaded");

  property p_read_adv;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      dat_rd && !rmw_q && !dummy_q && !VERTICAL_O |=> COLUMN_O == $past(COLUMN_O) + 8'h1;
  endproperty
  a_read_adv: assert property (p_read_adv) else $error("read column not advanced");

  property p_vert_adv;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      VERTICAL_O && (dat_wr || (dat_rd && !rmw_q && !dummy_q))
        |=> PAGE_O == $past(PAGE_O) + 5'h1;
  endproperty
  a_vert_adv: assert property (p_vert_adv) else $error("page not advanced");

  property p_dummy_read;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      dat_rd && dummy_q |=> RDATA_O == 8'h00 && $stable(col_q) && $stable(page_q);
  endproperty
  a_dummy_read: assert property (p_dummy_read) else $error("dummy read wrong");

  property p_busy_out;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      BUSY_O == busy;
  endproperty
  a_busy_out: assert property (p_busy_out) else $error("busy output differs");

  property p_col_hi;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      op_col_hi |=> col_q[7:4] == $past(WDATA_I[3:0]);
  endproperty
  a_col_hi: assert property (p_col_hi) else $error("column high nibble wrong");

  property p_rmw_enter;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      op_rmw |=> col_save_q == $past(col_q) && page_save_q == $past(page_q);
  endproperty
  a_rmw_enter: assert property (p_rmw_enter) else $error("address not saved");

  property p_scan;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      single && c[7:4] == `OHCD_CMD_SCAN |=> SCAN_REV_O == $past(WDATA_I[3]);
  endproperty
  a_scan: assert property (p_scan) else $error("scan direction wrong");

  property p_page_load;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      op_page |=> page_q == $past(WDATA_I[4:0]);
  endproperty
  a_page_load: assert property (p_page_load) else $error("page not loaded");

  assign COLUMN_O = col_q;
  assign PAGE_O   = page_q;

endmodule : ohcd_top
`default_nettype wire

// *** verification/ohcd_host.sv ***
// Purpose: host processor model on the command port
// Assumes: strobes are taken at the rising edge
// Notes:   released write data shows the inverse of the last byte
`timescale 1ns/1ns
`default_nettype none
module ohcd_host (
  // clock and read answer
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  // host strobes
  output logic            sel_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  // idle bus at time zero
  initial begin
    sel_o = 1'b0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one write strobe; a gap cycle follows so two strobes never merge
  task automatic wr(input logic s, input logic [7:0] d);
    @(posedge clk_i);
    sel_o <= s;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask : wr
  // the answer stands only in the cycle after the strobe
  task automatic rd(input logic s, output logic [7:0] d);
    @(posedge clk_i);
    sel_o <= s;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask : rd
endmodule : ohcd_host
`default_nettype wire

// *** verification/ohcd_top_bench.sv ***
// Purpose: self-checking bench of the host command decoder
// Assumes: host model drives the port, clock enable low only in the freeze case
// Notes:   expectations come from bench functions and constants
`timescale 1ns/1ns
`default_nettype none
`include "ohcd_regs.svh"
module ohcd_top_bench;
  localparam logic [5:0] IDENT = 6'h15;  // arbitrary value
  logic       clk = 1'b0;
  logic       rst_n, serial, sel, wr, rd, remap, entire, rev, pump_en, disp_on, scan, vert;
  logic       busy, t, ce;
  logic [1:0] res;
  logic [2:0] pump_f;
  logic [3:0] dis_lvl;
  logic [4:0] page;
  logic [7:0] wdata, rdata, contrast, clk_cfg, phase, com_lvl, segm_lvl, col, c, x, v;
  logic [7:0] d [4];
  logic [68:0] snap;
  int         miscompares = 0, cmp_count = 0, seed = 2580, cyc = 0;
  wire [68:0] all_w = {contrast, remap, entire, rev, pump_f, pump_en, disp_on, scan, res,
                       clk_cfg, phase, com_lvl, segm_lvl, dis_lvl, vert, col, page};
  // 125 MHz system clock
  always #4 clk = ~clk;
  ohcd_top #(.CHIP_IDENT(IDENT)) ohcd_top_i (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .CMD_DATA_SELECT_I(sel), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .SERIAL_MODE_I(serial), .RDATA_O(rdata), .CONTRAST_O(contrast),
    .SEG_REMAP_O(remap), .ENTIRE_ON_O(entire), .REVERSE_O(rev), .PUMP_SETTING_FIELD_O(pump_f),
    .PUMP_EN_O(pump_en), .DISPLAY_ON_O(disp_on), .SCAN_REV_O(scan), .RESOLUTION_O(res),
    .CLOCK_CFG_O(clk_cfg), .PHASE_O(phase), .COMMON_DESELECT_LEVEL_O(com_lvl),
    .SEGMENT_PRECHARGE_LEVEL_O(segm_lvl), .SEGMENT_DISCHARGE_LEVEL_O(dis_lvl),
    .VERTICAL_O(vert), .COLUMN_O(col), .PAGE_O(page), .BUSY_O(busy));
  ohcd_host ohcd_host_i (.clk_i(clk), .rdata_i(rdata), .sel_o(sel), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  // status byte: busy clear, off flag inverted from the on bit
  function automatic logic [7:0] stat_exp(input logic on);
    return {1'b0, ~on, IDENT};
  endfunction : stat_exp
  task automatic chk(input string n, input logic [68:0] got, input logic [68:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // command byte, then settle past the taking edge
  task automatic cmd(input logic [7:0] op);
    ohcd_host_i.wr(1'b0, op);
    @(negedge clk);
  endtask : cmd
  task automatic cmd2(input logic [7:0] op, input logic [7:0] arg);
    cmd(op);
    cmd(arg);
  endtask : cmd2
  // load both column nibbles, then throw the dummy byte away
  task automatic set_col(input logic [7:0] a);
    cmd({4'h0, a[3:0]});
    cmd({4'h1, a[7:4]});
    ohcd_host_i.rd(1'b1, v);
    chk("dummy column", col, a);
    chk("dummy data", v, 8'h00);
  endtask : set_col
  // a hang is cut short well past the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    serial = 1'b0;
    ce = 1'b1;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("busy after reset", busy, 1'b1);
    cmd(8'hAF);
    repeat (3) @(negedge clk);
    // pump 81: field 0, enable 1; the early display-on must be dropped while busy
    chk("reset", all_w, {`OHCD_RST_CONTRAST, 7'h01, 2'h0, `OHCD_RST_RES, `OHCD_RST_CLOCK,
      `OHCD_RST_PHASE, `OHCD_RST_LVL, `OHCD_RST_LVL, `OHCD_RST_SEG_DIS, 1'b0, `OHCD_RST_COL,
      `OHCD_RST_PAGE});
    chk("busy released", busy, 1'b0);
    // single-byte settings cleared then set
    for (int i = 0; i < 2; i++) begin
      t = i[0];
      cmd({7'h50, t});
      cmd({7'h52, t});
      cmd({7'h53, t});
      cmd({7'h57, t});
      cmd({7'h10, t});
      cmd({4'hC, t, 3'h5});
      chk("remap", remap, t);
      chk("entire", entire, t);
      chk("reverse", rev, t);
      chk("display", disp_on, t);
      chk("vertical", vert, t);
      chk("scan", scan, t);
      ohcd_host_i.rd(1'b0, v);
      chk("status", v, stat_exp(t));
    end
    // double-byte settings and the 3xH discharge level with random arguments
    for (int k = 0; k < 4; k++) begin
      x = 8'($random(seed));
      cmd2(8'h81, x);
      cmd2(8'hAD, x);
      cmd2(8'hA9, x);
      cmd2(8'hD5, x);
      cmd2(8'hD9, x);
      cmd2(8'hDB, x);
      cmd2(8'hDC, x);
      cmd2(8'hB0, {3'h0, x[4:0]});
      cmd({4'h3, x[3:0]});
      chk("contrast", contrast, x);
      chk("pump", {pump_f, pump_en}, x[3:0]);
      chk("resolution", res, x[1:0]);
      chk("clock", clk_cfg, x);
      chk("phase", phase, x);
      chk("common level", com_lvl, x);
      chk("segment level", segm_lvl, x);
      chk("page", page, x[4:0]);
      chk("discharge", dis_lvl, x[3:0]);
    end
    snap = all_w;
    cmd(8'hE3);
    cmd(8'h45);
    chk("no operation", all_w, snap);
    // with the enable low a reverse-off command must not land
    ce <= 1'b0;
    cmd(8'hA6);
    chk("frozen", all_w, snap);
    ce <= 1'b1;
    // stream bytes into page 3 and read them back
    cmd(8'h20);
    cmd2(8'hB0, 8'h03);
    c = 8'($random(seed)) & 8'h7F;
    set_col(c);
    for (int j = 0; j < 4; j++) begin
      d[j] = 8'($random(seed));
      ohcd_host_i.wr(1'b1, d[j]);
    end
    @(negedge clk);
    chk("write column", col, c + 8'h04);
    set_col(c);
    for (int j = 0; j < 4; j++) begin
      ohcd_host_i.rd(1'b1, v);
      chk("read data", v, d[j]);
    end
    chk("read column", col, c + 8'h04);
    // modify mode: reads hold the column, the end command restores it
    set_col(c);
    cmd(8'hE0);
    ohcd_host_i.rd(1'b1, v);
    chk("modify read", v, d[0]);
    chk("modify column", col, c);
    x = ~d[0];
    ohcd_host_i.wr(1'b1, x);
    @(negedge clk);
    chk("modify write", col, c + 8'h01);
    cmd(8'hEE);
    chk("end column", col, c);
    set_col(c);
    ohcd_host_i.rd(1'b1, v);
    chk("modified byte", v, x);
    // vertical mode advances the page on a read
    cmd(8'h21);
    set_col(c);
    ohcd_host_i.rd(1'b1, v);
    chk("vertical data", v, x);
    chk("vertical address", {col, page}, {c, 5'h04});
    // serial port has no data read path
    serial <= 1'b1;
    set_col(c);
    ohcd_host_i.rd(1'b1, v);
    chk("serial read", v, 8'h00);
    end_of_test();
  end
endmodule : ohcd_top_bench
`default_nettype wire
